// *** mlm_top.sv ***
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module mlm_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);

  // Sector-count and LBA registers keep the current and the previous byte written.
  logic [7:0]  feature_r;
  logic [7:0]  sc_cur_r;
  logic [7:0]  sc_prev_r;
  logic [7:0]  low_cur_r;
  logic [7:0]  low_prev_r;
  logic [7:0]  mid_cur_r;
  logic [7:0]  mid_prev_r;
  logic [7:0]  high_cur_r;
  logic [7:0]  high_prev_r;
  logic [7:0]  drive_sel_r;
  logic [7:0]  dev_ctrl_r;
  logic [7:0]  error_r;
  logic [7:0]  status_r;
  logic [4:0]  config_r;
  logic [47:0] max_block_limit_r;
  logic        limit_nonvol_r;
  logic        nonvol_used_r;
  logic        native_prev_r;
  logic        multi_en_r;
  logic [4:0]  multi_size_r;
  logic [27:0] id_60_61_r;
  logic [47:0] id_100_103_r;
  logic [1:0]  irq_status_r;
  logic [1:0]  irq_mask_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        irq_r;

  logic        setup;
  logic        wr_acc;
  logic        cmd_go;
  logic [7:0]  cmd;
  logic        mapped;
  logic [31:0] rd_val;
  logic [47:0] req_limit;
  logic [47:0] acc_addr;
  logic        ext_access;
  logic        media_access;
  logic        multi_cmd;
  logic        limit_abort;
  logic        size_ok;
  logic        abort;
  logic        hob;

  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & pready_r & pwrite;
  assign cmd_go = wr_acc & (paddr == mlm_pkg::ADDR_COMMAND);
  assign cmd    = pwdata[7:0];
  assign hob    = dev_ctrl_r[mlm_pkg::DEVCTL_HOB_BIT];

  assign req_limit = {high_prev_r, mid_prev_r, low_prev_r, high_cur_r, mid_cur_r, low_cur_r};

  assign ext_access = (cmd == mlm_pkg::CMD_READ_SECT_EXT) | (cmd == mlm_pkg::CMD_WRITE_SECT_EXT) |
                      (cmd == mlm_pkg::CMD_READ_MULTI_EXT) | (cmd == mlm_pkg::CMD_WRITE_MULTI_EXT);
  assign multi_cmd  = (cmd == mlm_pkg::CMD_READ_MULTIPLE) | (cmd == mlm_pkg::CMD_WRITE_MULTIPLE) |
                      (cmd == mlm_pkg::CMD_READ_MULTI_EXT) | (cmd == mlm_pkg::CMD_WRITE_MULTI_EXT);
  assign media_access = ext_access | multi_cmd | (cmd == mlm_pkg::CMD_READ_SECT) |
                        (cmd == mlm_pkg::CMD_WRITE_SECT);
  assign acc_addr = ext_access ? req_limit :
                    {20'h0_0000, drive_sel_r[mlm_pkg::DS_LBA_HI_MSB:0], high_cur_r, mid_cur_r,
                     low_cur_r};

  assign size_ok = (sc_cur_r == 8'h00) | (sc_cur_r == 8'h01) | (sc_cur_r == 8'h02) |
                   (sc_cur_r == 8'h04) | (sc_cur_r == 8'h08) | (sc_cur_r == 8'h10);

  always_comb begin
    limit_abort = 1'b0;
    if (!config_r[mlm_pkg::CFG_SUPPORTED] || (req_limit > mlm_pkg::NATIVE_MAX)) begin
      limit_abort = 1'b1;
    end
    if (!native_prev_r) begin
      limit_abort = 1'b1;
    end
    if (config_r[mlm_pkg::CFG_HPA28]) begin
      limit_abort = 1'b1;
    end
    if (config_r[mlm_pkg::CFG_LOCKED] || config_r[mlm_pkg::CFG_FROZEN]) begin
      limit_abort = 1'b1;
    end
    if (sc_cur_r[mlm_pkg::SC_NONVOL_BIT]) begin
      if (nonvol_used_r) begin
        limit_abort = 1'b1;
      end
      if (config_r[mlm_pkg::CFG_OFFSET]) begin
        limit_abort = 1'b1;
      end
    end
  end

  always_comb begin
    abort = 1'b0;
    case (cmd)
      mlm_pkg::CMD_SET_LIMIT_EXT: abort = limit_abort;
      mlm_pkg::CMD_SET_MULTIPLE:  abort = ~size_ok;
      default: begin
        if (media_access && (acc_addr > max_block_limit_r)) begin
          abort = 1'b1;
        end
        if (multi_cmd && !multi_en_r) begin
          abort = 1'b1;
        end
      end
    endcase
  end

  // Host-side task-file writes; a command completion may return bytes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feature_r   <= 8'h00;
      sc_cur_r    <= 8'h00;
      sc_prev_r   <= 8'h00;
      low_cur_r   <= 8'h00;
      low_prev_r  <= 8'h00;
      mid_cur_r   <= 8'h00;
      mid_prev_r  <= 8'h00;
      high_cur_r  <= 8'h00;
      high_prev_r <= 8'h00;
      drive_sel_r <= 8'h00;
      dev_ctrl_r  <= 8'h00;
    end else if (cmd_go && (cmd == mlm_pkg::CMD_READ_NATIVE_EXT)) begin
      {high_prev_r, mid_prev_r, low_prev_r} <= mlm_pkg::NATIVE_MAX[47:24];
      {high_cur_r, mid_cur_r, low_cur_r}    <= mlm_pkg::NATIVE_MAX[23:0];
    end else if (cmd_go && (cmd == mlm_pkg::CMD_SET_LIMIT_EXT) && !limit_abort) begin
      {high_prev_r, mid_prev_r, low_prev_r} <= req_limit[47:24];
      {high_cur_r, mid_cur_r, low_cur_r}    <= req_limit[23:0];
    end else if (wr_acc) begin
      case (paddr)
        mlm_pkg::ADDR_FEATURE: begin
          feature_r <= pwdata[7:0];
        end
        mlm_pkg::ADDR_SECT_CNT: begin
          sc_prev_r <= sc_cur_r;
          sc_cur_r  <= pwdata[7:0];
        end
        mlm_pkg::ADDR_LBA_LOW: begin
          low_prev_r <= low_cur_r;
          low_cur_r  <= pwdata[7:0];
        end
        mlm_pkg::ADDR_LBA_MID: begin
          mid_prev_r <= mid_cur_r;
          mid_cur_r  <= pwdata[7:0];
        end
        mlm_pkg::ADDR_LBA_HIGH: begin
          high_prev_r <= high_cur_r;
          high_cur_r  <= pwdata[7:0];
        end
        mlm_pkg::ADDR_DRIVE_SEL: begin
          drive_sel_r <= pwdata[7:0];
        end
        mlm_pkg::ADDR_DEV_CTRL: begin
          dev_ctrl_r <= pwdata[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Error and status follow the last completed command.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_r  <= 8'h00;
      status_r <= mlm_pkg::STATUS_IDLE;
    end else if (cmd_go) begin
      error_r  <= 8'h00 | (8'(abort) << mlm_pkg::ERR_ABORT_BIT);
      status_r <= mlm_pkg::STATUS_IDLE | (8'(abort) << mlm_pkg::STAT_ERR_BIT);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_r <= mlm_pkg::CFG_RESET;
    end else if (wr_acc && (paddr == mlm_pkg::ADDR_CONFIG)) begin
      config_r <= pwdata[4:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      native_prev_r <= 1'b0;
    end else if (cmd_go) begin
      native_prev_r <= (cmd == mlm_pkg::CMD_READ_NATIVE_EXT);
    end
  end

  // The limit and its persistence choice; reset returns all of them to defaults, a nonvolatile limit too.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      max_block_limit_r <= mlm_pkg::NATIVE_MAX;
      limit_nonvol_r    <= 1'b0;
      nonvol_used_r     <= 1'b0;
      id_60_61_r        <= mlm_pkg::CEILING_28[27:0];
      id_100_103_r      <= mlm_pkg::NATIVE_MAX;
    end else if (cmd_go && (cmd == mlm_pkg::CMD_SET_LIMIT_EXT) && !limit_abort) begin
      max_block_limit_r <= req_limit;
      limit_nonvol_r    <= sc_cur_r[mlm_pkg::SC_NONVOL_BIT];
      if (sc_cur_r[mlm_pkg::SC_NONVOL_BIT]) begin
        nonvol_used_r <= 1'b1;
      end
      id_100_103_r <= req_limit;
      if (req_limit <= mlm_pkg::CEILING_28) begin
        id_60_61_r <= req_limit[27:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      multi_en_r   <= 1'b0;
      multi_size_r <= 5'h00;
    end else if (cmd_go && (cmd == mlm_pkg::CMD_SET_MULTIPLE)) begin
      if (size_ok) begin
        multi_en_r   <= (sc_cur_r != 8'h00);
        multi_size_r <= sc_cur_r[4:0];
      end else begin
        multi_en_r   <= 1'b0;
        multi_size_r <= 5'h00;
      end
    end
  end

  // Interrupt status: a new event wins over a write-one-to-clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_r <= 2'b00;
    end else begin
      irq_status_r <= (irq_status_r &
                       ~((wr_acc && (paddr == mlm_pkg::ADDR_IRQ_STATUS)) ? pwdata[1:0] : 2'b00)) |
                      {cmd_go & abort, cmd_go};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_r <= 2'b00;
    end else if (wr_acc && (paddr == mlm_pkg::ADDR_IRQ_MASK)) begin
      irq_mask_r <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_status_r & irq_mask_r);
    end
  end

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      mlm_pkg::ADDR_FEATURE:    rd_val = 32'h0000_0000;
      mlm_pkg::ADDR_COMMAND:    rd_val = 32'h0000_0000;
      mlm_pkg::ADDR_SECT_CNT:   rd_val = {24'h00_0000, hob ? sc_prev_r : sc_cur_r};
      mlm_pkg::ADDR_LBA_LOW:    rd_val = {24'h00_0000, hob ? low_prev_r : low_cur_r};
      mlm_pkg::ADDR_LBA_MID:    rd_val = {24'h00_0000, hob ? mid_prev_r : mid_cur_r};
      mlm_pkg::ADDR_LBA_HIGH:   rd_val = {24'h00_0000, hob ? high_prev_r : high_cur_r};
      mlm_pkg::ADDR_DRIVE_SEL:  rd_val = {24'h00_0000, drive_sel_r};
      mlm_pkg::ADDR_ERROR:      rd_val = {24'h00_0000, error_r};
      mlm_pkg::ADDR_STATUS:     rd_val = {24'h00_0000, status_r};
      mlm_pkg::ADDR_DEV_CTRL:   rd_val = {24'h00_0000, dev_ctrl_r};
      mlm_pkg::ADDR_CONFIG:     rd_val = {24'h00_0000, 3'b000, config_r};
      mlm_pkg::ADDR_LIMIT_LO:   rd_val = max_block_limit_r[31:0];
      mlm_pkg::ADDR_LIMIT_HI:   rd_val = {limit_nonvol_r, nonvol_used_r, 14'h0000,
                                          max_block_limit_r[47:32]};
      mlm_pkg::ADDR_MULTI:      rd_val = {native_prev_r, 23'h00_0000, 2'b00, multi_en_r,
                                          multi_size_r};
      mlm_pkg::ADDR_ID_60_61:   rd_val = {4'h0, id_60_61_r};
      mlm_pkg::ADDR_ID_100_LO:  rd_val = id_100_103_r[31:0];
      mlm_pkg::ADDR_ID_100_HI:  rd_val = {16'h0000, id_100_103_r[47:32]};
      mlm_pkg::ADDR_IRQ_STATUS: rd_val = {30'h0000_0000, irq_status_r};
      mlm_pkg::ADDR_IRQ_MASK:   rd_val = {30'h0000_0000, irq_mask_r};
      default:                  mapped = 1'b0;
    endcase
  end

  // Read data and the answer are prepared in the setup cycle, so no wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r  <= (setup && !pwrite) ? rd_val : 32'h0000_0000;
      pready_r  <= setup;
      pslverr_r <= setup & ~mapped;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign irq     = irq_r;

endmodule : mlm_top
`default_nettype wire

// *** mlm_pkg.sv ***
// What this block does
// - Set-limit-extended is aborted unless read-native-limit-extended came right before.
// - Media accesses beyond the accepted limit are refused with abort.
// - Abort set-limit when limit exceeds capacity or command is unsupported.
// - Abort set-limit when an older 28-bit protected area exists.
// - Abort set-limit while limit-locked or limit-frozen.
// - Only one nonvolatile set-limit is accepted until the next reset.
// - Sector-count bit 0 selects nonvolatile (1) or volatile (0) limit.
// - Nonvolatile request in offset-addressing mode is invalid and aborted.
// - Limit above 28-bit ceiling updates identify 103:100 only.
// - Limit at or below ceiling updates identify 103:100 and 61:60.
// - Every refusal sets error abort bit and status error flag.
// - Command C6h enables multiple transfers and stores block size.
// - Accepted block sizes are 0, 1, 2, 4, 8 and 16.
// - Block size zero leaves multiple transfers disabled.
// - Unsupported block size aborts and disables multiple transfers.
package mlm_pkg;

  localparam logic [7:0] ADDR_FEATURE     = 8'h00;
  localparam logic [7:0] ADDR_SECT_CNT    = 8'h04;
  localparam logic [7:0] ADDR_LBA_LOW     = 8'h08;
  localparam logic [7:0] ADDR_LBA_MID     = 8'h0c;
  localparam logic [7:0] ADDR_LBA_HIGH    = 8'h10;
  localparam logic [7:0] ADDR_DRIVE_SEL   = 8'h14;
  localparam logic [7:0] ADDR_COMMAND     = 8'h18;
  localparam logic [7:0] ADDR_ERROR       = 8'h1c;
  localparam logic [7:0] ADDR_STATUS      = 8'h20;
  localparam logic [7:0] ADDR_DEV_CTRL    = 8'h24;
  localparam logic [7:0] ADDR_CONFIG      = 8'h28;
  localparam logic [7:0] ADDR_LIMIT_LO    = 8'h2c;
  localparam logic [7:0] ADDR_LIMIT_HI    = 8'h30;
  localparam logic [7:0] ADDR_MULTI       = 8'h34;
  localparam logic [7:0] ADDR_ID_60_61    = 8'h38;
  localparam logic [7:0] ADDR_ID_100_LO   = 8'h3c;
  localparam logic [7:0] ADDR_ID_100_HI   = 8'h40;
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h44;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'h48;

  localparam logic [7:0] CMD_READ_NATIVE_EXT = 8'h27;
  localparam logic [7:0] CMD_SET_LIMIT_EXT   = 8'h37;
  localparam logic [7:0] CMD_SET_MULTIPLE    = 8'hc6;
  localparam logic [7:0] CMD_READ_MULTIPLE   = 8'hc4;
  localparam logic [7:0] CMD_WRITE_MULTIPLE  = 8'hc5;
  localparam logic [7:0] CMD_READ_MULTI_EXT  = 8'h29;
  localparam logic [7:0] CMD_WRITE_MULTI_EXT = 8'h39;
  localparam logic [7:0] CMD_READ_SECT       = 8'h20;
  localparam logic [7:0] CMD_WRITE_SECT      = 8'h30;
  localparam logic [7:0] CMD_READ_SECT_EXT   = 8'h24;
  localparam logic [7:0] CMD_WRITE_SECT_EXT  = 8'h34;

  localparam int          ERR_ABORT_BIT  = 2;
  localparam int          STAT_READY_BIT = 6;
  localparam int          STAT_ERR_BIT   = 0;
  localparam int          DEVCTL_HOB_BIT = 7;
  localparam int          SC_NONVOL_BIT  = 0;
  localparam int          DS_LBA_HI_MSB  = 3;

  localparam int          CFG_SUPPORTED  = 0;
  localparam int          CFG_OFFSET     = 1;
  localparam int          CFG_LOCKED     = 2;
  localparam int          CFG_FROZEN     = 3;
  localparam int          CFG_HPA28      = 4;
  localparam logic [4:0]  CFG_RESET      = 5'h01;

  localparam int          IRQ_DONE_BIT   = 0;
  localparam int          IRQ_ABORT_BIT  = 1;

  // Highest block address of the media; plain default.
  localparam logic [47:0] NATIVE_MAX     = 48'h0000_ffff_ffff;
  localparam logic [47:0] CEILING_28     = 48'h0000_0fff_ffff;
  localparam logic [7:0]  STATUS_IDLE    = 8'h40;

endpackage : mlm_pkg

// *** mlm_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module mlm_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_ok;
  assign rd_ok = pready && !pwrite && !pslverr;
  a_ready_answer: assert property (psel && !penable |=> pready && psel && penable)
    else $error("no answer after setup");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
  a_slverr_ready: assert property (pslverr |-> pready) else $error("stray slave error");
  a_unmapped_err: assert property (pready && paddr > mlm_pkg::ADDR_IRQ_MASK |-> pslverr)
    else $error("unmapped access accepted");
  a_data_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
  a_error_form: assert property (rd_ok && paddr == mlm_pkg::ADDR_ERROR |-> (prdata & ~32'h4) == 0)
    else $error("error register bad");
  a_status_form: assert property (rd_ok && paddr == mlm_pkg::ADDR_STATUS |->
    prdata[31:7] == 0 && prdata[5] == 1'b0 && prdata[2] == 1'b0) else $error("status bad");
  a_multi_size: assert property (rd_ok && paddr == mlm_pkg::ADDR_MULTI && prdata[5] |->
    prdata[4:0] inside {5'h01, 5'h02, 5'h04, 5'h08, 5'h10}) else $error("bad block size");
  a_irq_masked: assert property (pready && pwrite && paddr == mlm_pkg::ADDR_IRQ_MASK
    && pwdata[1:0] == 2'h0 |=> ##1 !irq) else $error("masked interrupt seen");
endmodule : mlm_props
bind mlm_top mlm_props mlm_props_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .irq);
`default_nettype wire

// *** mlm_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module mlm_host (
  input  wire logic        pclk,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // One bus transfer; released address and write data show the inverse of their last value, pwrite keeps its value.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench watchdog ends a wait for the answer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : mlm_host
`default_nettype wire

// *** test_max_lba_and_multiple_cmds.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_max_lba_and_multiple_cmds;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, irq, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [31:0] r = 32'hec83;
  int          failures = 0;
  int          comparisons = 0;
  int          ok_sz[$] = '{0, 1, 2, 4, 8, 16};
  logic [7:0]  mc[4] = '{8'hc4, 8'hc5, 8'h29, 8'h39};
  logic [4:0]  cv[5] = '{5'h00, 5'h05, 5'h09, 5'h11, 5'h03};
  logic [47:0] lim_m = mlm_pkg::NATIVE_MAX;
  logic [47:0] id100_m = mlm_pkg::NATIVE_MAX;
  logic [27:0] id60_m = mlm_pkg::CEILING_28[27:0];
  logic [4:0]  cfg_m = mlm_pkg::CFG_RESET;
  bit          nv_m, used_m, en_m;
  mlm_top mlm_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq);
  mlm_host mlm_host_inst (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  initial forever #2.5 pclk = ~pclk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic final_report;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    mlm_host_inst.xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    mlm_host_inst.xfer(1'b0, a, 32'h0, q, e);
  endtask : rd
  task automatic cmd(input logic [7:0] c, input bit ab);
    wr(mlm_pkg::ADDR_COMMAND, {24'h0, c});
    rd(mlm_pkg::ADDR_ERROR);
    chk(q, {29'h0, ab, 2'h0});
    rd(mlm_pkg::ADDR_STATUS);
    chk(q, {24'h0, mlm_pkg::STATUS_IDLE | {7'h0, ab}});
  endtask : cmd
  task automatic bytes(input logic [47:0] v);
    for (int i = 0; i < 3; i++) begin
      wr(mlm_pkg::ADDR_LBA_LOW + 8'(4 * i), {24'h0, v[24 + 8 * i +: 8]});
      wr(mlm_pkg::ADDR_LBA_LOW + 8'(4 * i), {24'h0, v[8 * i +: 8]});
    end
  endtask : bytes
  task automatic setlim(input logic [47:0] v, input bit nv, input int pre);
    bit ab;
    ab = pre != 1 || !cfg_m[0] || |cfg_m[4:2] || v > mlm_pkg::NATIVE_MAX
      || (nv && (cfg_m[1] || used_m));
    if (pre > 0) wr(mlm_pkg::ADDR_COMMAND, 32'h27);
    if (pre > 1) wr(mlm_pkg::ADDR_COMMAND, 32'he5);
    wr(mlm_pkg::ADDR_SECT_CNT, 32'h0);
    wr(mlm_pkg::ADDR_SECT_CNT, {31'h0, nv});
    bytes(v);
    cmd(mlm_pkg::CMD_SET_LIMIT_EXT, ab);
    if (!ab) begin
      lim_m = v;
      nv_m = nv;
      used_m |= nv;
      id100_m = v;
      if (v <= mlm_pkg::CEILING_28) id60_m = v[27:0];
    end
    rd(mlm_pkg::ADDR_LIMIT_LO);
    chk(q, lim_m[31:0]);
    rd(mlm_pkg::ADDR_LIMIT_HI);
    chk(q & 32'hc000ffff, {nv_m, used_m, 14'h0, lim_m[47:32]});
    rd(mlm_pkg::ADDR_ID_60_61);
    chk(q, {4'h0, id60_m});
    rd(mlm_pkg::ADDR_ID_100_LO);
    chk(q, id100_m[31:0]);
    rd(mlm_pkg::ADDR_ID_100_HI);
    chk(q, {16'h0, id100_m[47:32]});
    if (!ab) begin
      wr(mlm_pkg::ADDR_DEV_CTRL, 32'h80);
      rd(mlm_pkg::ADDR_LBA_HIGH);
      chk(q, {24'h0, v[47:40]});
      wr(mlm_pkg::ADDR_DEV_CTRL, 32'h0);
      rd(mlm_pkg::ADDR_LBA_HIGH);
      chk(q, {24'h0, v[23:16]});
    end
  endtask : setlim
  task automatic setmul(input logic [7:0] s);
    bit ok;
    ok = s inside {ok_sz};
    en_m = ok && s != 8'h0;
    wr(mlm_pkg::ADDR_SECT_CNT, {24'h0, s});
    cmd(mlm_pkg::CMD_SET_MULTIPLE, !ok);
    rd(mlm_pkg::ADDR_MULTI);
    chk(q, {26'h0, en_m, ok ? s[4:0] : 5'h00});
    bytes(48'h0);
    cmd(mc[s[1:0]], !en_m);
  endtask : setmul
  initial begin
    #50000;
    failures++;
    final_report;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(mlm_pkg::ADDR_STATUS);
    chk(q, {24'h0, mlm_pkg::STATUS_IDLE});
    rd(mlm_pkg::ADDR_CONFIG);
    chk(q, {27'h0, mlm_pkg::CFG_RESET});
    wr(mlm_pkg::ADDR_ERROR, 32'hff);
    rd(mlm_pkg::ADDR_ERROR);
    chk(q, 32'h0);
    rd(8'h80);
    chk({31'h0, e}, 32'h1);
    wr(mlm_pkg::ADDR_DRIVE_SEL, 32'h0);
    wr(mlm_pkg::ADDR_IRQ_MASK, 32'h3);
    setlim(48'h0000_0100_0000, 1'b0, 0);
    chk({31'h0, irq}, 32'h1);
    rd(mlm_pkg::ADDR_IRQ_STATUS);
    chk(q & 32'h3, 32'h3);
    wr(mlm_pkg::ADDR_IRQ_STATUS, 32'h3);
    rd(mlm_pkg::ADDR_IRQ_STATUS);
    chk(q & 32'h3, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(mlm_pkg::ADDR_IRQ_MASK, 32'h0);
    setlim(48'h0000_0100_0000, 1'b0, 2);
    chk({31'h0, irq}, 32'h0);
    wr(mlm_pkg::ADDR_IRQ_MASK, 32'h3);
    for (int i = 0; i < 5; i++) begin
      cfg_m = cv[i];
      wr(mlm_pkg::ADDR_CONFIG, {27'h0, cfg_m});
      setlim(48'h0000_0100_0000, i == 4, 1);
    end
    setlim(48'h0000_0200_0000, 1'b0, 1);
    cfg_m = mlm_pkg::CFG_RESET;
    wr(mlm_pkg::ADDR_CONFIG, {27'h0, cfg_m});
    setlim(48'h0001_0000_0000, 1'b0, 1);
    setlim(48'h0000_1000_0000, 1'b1, 1);
    setlim(48'h0000_0800_0000, 1'b1, 1);
    setlim(48'h0000_0800_0000, 1'b0, 1);
    bytes(48'h0000_0800_0000);
    cmd(mlm_pkg::CMD_READ_SECT_EXT, 1'b0);
    bytes(48'h0000_0800_0001);
    cmd(mlm_pkg::CMD_WRITE_SECT_EXT, 1'b1);
    wr(mlm_pkg::ADDR_DRIVE_SEL, 32'h8);
    bytes(48'h0000_0000_0001);
    cmd(mlm_pkg::CMD_WRITE_SECT, 1'b1);
    bytes(48'h0);
    cmd(mlm_pkg::CMD_READ_SECT, 1'b0);
    for (int i = 0; i < 24; i++) begin
      setmul(i < 6 ? 8'(ok_sz[i]) : {3'h0, r[4:0]});
      r = lfsr(r);
    end
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    used_m = 1'b0;
    rd(mlm_pkg::ADDR_STATUS);
    chk(q, {24'h0, mlm_pkg::STATUS_IDLE});
    rd(mlm_pkg::ADDR_MULTI);
    chk(q, 32'h0);
    setlim(48'h0000_0800_0000, 1'b1, 1);
    final_report;
  end
endmodule : test_max_lba_and_multiple_cmds
`default_nettype wire
